// [bench/satu_core_monitor.sv]
// assertions on the ports of the storage address and trap unit
// assumes stage edges and loads are one-cycle pulses sampled on clk
`timescale 1ns/1ps
`include "satu_regs.vh"
module satu_core_monitor #(
	parameter [13:0] TRAP_VECTOR = 14'h0040
) (
	input wire clk,
	input wire srst,
	input wire stage_one_clock_edge,
	input wire stage_two_half_clock_edge,
	input wire stage_six_clock_edge,
	input wire stage_seven_clock_edge,
	input wire fetch_ptr_load,
	input wire instr_fetch,
	input wire operand_fetch,
	input wire [31:0] operand_addr,
	input wire exec_trap,
	input wire [13:0] exec_trap_vector,
	input wire trap_return,
	input wire [31:0] instruction_fetch_pointer_r,
	input wire [31:0] cache_addr_r,
	input wire [31:0] tb_addr_r,
	input wire [31:0] memory_address_reg_r,
	input wire [31:0] instruction_backup_addr_r,
	input wire [31:0] operand_backup_addr_r,
	input wire operand_trap_r,
	input wire instr_trap_pending_r,
	input wire trap_branch_r,
	input wire [13:0] trap_target_r,
	input wire [2:0] trap_cause_r,
	input wire return_valid_r
);
default clocking cb @(posedge clk); endclocking
default disable iff (srst);
////////////////////////////////////////////////////////////////////////////////
// handler window as seen from the ports; loads are frozen inside it
reg busy_r;
always @(posedge clk) begin
	if (srst || trap_return)
		busy_r <= 1'b0;
	else if (trap_branch_r)
		busy_r <= 1'b1;
end
////////////////////////////////////////////////////////////////////////////////
a_stage_one_copy: assert property (stage_one_clock_edge && instr_fetch && !busy_r
	|=> cache_addr_r == $past(instruction_fetch_pointer_r) && tb_addr_r == cache_addr_r)
	else $error("fetch pointer not copied to address registers");
a_instr_backup: assert property (stage_one_clock_edge && instr_fetch && !busy_r
	|=> memory_address_reg_r == cache_addr_r && instruction_backup_addr_r == cache_addr_r)
	else $error("instruction backup or memory address not loaded");
a_operand_load: assert property (stage_six_clock_edge && operand_fetch && !busy_r
	&& !(stage_one_clock_edge && instr_fetch)
	|=> operand_backup_addr_r == $past(operand_addr) && cache_addr_r == $past(operand_addr))
	else $error("operand address not loaded");
a_fetch_step: assert property (stage_two_half_clock_edge && !fetch_ptr_load
	&& !instr_trap_pending_r && !busy_r
	|=> instruction_fetch_pointer_r == $past(instruction_fetch_pointer_r) + 32'h0000_0002)
	else $error("fetch pointer did not advance by two");
a_trap_hold: assert property (instr_trap_pending_r && stage_two_half_clock_edge
	&& !fetch_ptr_load |=> $stable(instruction_fetch_pointer_r))
	else $error("fetch pointer advanced under a trap");
a_trap_vector: assert property (trap_branch_r && trap_cause_r != 3'h6
	|-> trap_target_r == TRAP_VECTOR)
	else $error("memory trap target is not the fixed vector");
a_exec_wins: assert property (stage_seven_clock_edge && exec_trap && !busy_r
	|=> trap_branch_r && trap_cause_r == 3'h6 && trap_target_r == $past(exec_trap_vector))
	else $error("execution trap not taken first");
a_op_trap_pair: assert property (operand_trap_r |-> trap_branch_r ##1 !trap_branch_r)
	else $error("operand trap without a single branch pulse");
a_return_cause: assert property (return_valid_r |-> $past(trap_return))
	else $error("return without a request");
c_regfile: cover property (trap_branch_r && trap_cause_r == 3'h3);
c_exec: cover property (trap_branch_r && trap_cause_r == 3'h6);
c_return: cover property (return_valid_r);
c_flat: cover property (trap_branch_r && trap_cause_r == 3'h4);
endmodule // satu_core_monitor
bind satu_core satu_core_monitor #(.TRAP_VECTOR(TRAP_VECTOR)) u_satu_core_monitor (.clk, .srst,
	.stage_one_clock_edge, .stage_two_half_clock_edge, .stage_six_clock_edge,
	.stage_seven_clock_edge, .fetch_ptr_load, .instr_fetch, .operand_fetch, .operand_addr,
	.exec_trap, .exec_trap_vector, .trap_return, .instruction_fetch_pointer_r, .cache_addr_r,
	.tb_addr_r, .memory_address_reg_r, .instruction_backup_addr_r, .operand_backup_addr_r,
	.operand_trap_r, .instr_trap_pending_r, .trap_branch_r, .trap_target_r, .trap_cause_r,
	.return_valid_r);

// [bench/satu_pcu_model.sv]
// pipeline control and microcode sequencer stand-in
// assumes one trap at a time; slow stretches drain and handler time
`timescale 1ns/1ps
module satu_pcu_model (
	input wire clk,
	input wire srst,
	input wire slow,
	input wire instr_trap_pending_r,
	input wire trap_branch_r,
	output reg pipe_drained,
	output reg trap_return
);
reg [3:0] drain_r;
reg [3:0] hold_r;
wire [3:0] lim = slow ? 4'h9 : 4'h1;
always @(posedge clk) begin
	if (srst || !instr_trap_pending_r)
		drain_r <= 4'h0;
	else if (drain_r <= lim)
		drain_r <= drain_r + 4'h1;
	// one drain report per pending trap, so no second trap is let in
	pipe_drained <= !srst && instr_trap_pending_r && drain_r == lim;
	if (srst)
		hold_r <= 4'h0;
	else if (trap_branch_r)
		hold_r <= lim + 4'h1;
	else if (hold_r != 4'h0)
		hold_r <= hold_r - 4'h1;
	trap_return <= !srst && hold_r == 4'h1;
end
endmodule // satu_pcu_model

// [bench/storage_address_and_trap_unit_test.sv]
// self-checking bench for the storage address and trap unit
// assumes the pipeline model answers every trap with a return
`timescale 1ns/1ps
module storage_address_and_trap_unit_test;
localparam [13:0] VEC = 14'h0040;
logic clk, srst, stage_one_clock_edge, stage_two_clock_edge, stage_two_half_clock_edge;
logic stage_six_clock_edge, stage_seven_clock_edge, fetch_ptr_load, instr_fetch, operand_fetch;
logic is32_access, instr_miss, operand_miss, unaligned_step, str_src_load, str_dst_load;
logic str_src_step, str_dst_step, str_down, str_to_mem_addr_src, str_to_mem_addr_dst;
logic access_denied, mapped_mode, exec_trap, tb_refill, slow;
logic [31:0] fetch_ptr_value, operand_addr, regfile_lo, regfile_hi, ep;
logic [15:0] str_low_value, keys, tb_refill_page;
logic [13:0] exec_trap_vector, cur_uaddr;
logic [2:0] purge_count;
logic [1:0] cpu_mode;
wire pipe_drained, trap_return, operand_trap_r, instr_trap_pending_r, trap_branch_r;
wire return_valid_r, stack_overflow_r;
wire [31:0] instruction_fetch_pointer_r, cache_addr_r, tb_addr_r, memory_address_reg_r;
wire [31:0] instruction_backup_addr_r, operand_backup_addr_r, string_source_addr_r;
wire [31:0] string_dest_addr_r;
wire [15:0] phys_page_r;
wire [13:0] trap_target_r, return_uaddr_r;
wire [2:0] trap_cause_r;
int errors = 0;
int compares = 0;
satu_core #(.TRAP_VECTOR(VEC)) u_satu_core (.*);
satu_pcu_model u_satu_pcu_model (.clk, .srst, .slow, .instr_trap_pending_r, .trap_branch_r,
	.pipe_drained, .trap_return);
initial begin
	clk = 1'b0;
	forever #12.5 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task go; @(negedge clk); endtask
task give_verdict;
	$display("errors %0d compares %0d", errors, compares);
	if (errors == 0 && compares > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
task chk(input [31:0] seen, input [31:0] exp, input string nm);
	compares++;
	if (seen !== exp) begin
		errors++;
		$display("unexpected %s expected %h seen %h", nm, exp, seen);
	end
endtask
task await(input bit ret);
	int i;
	for (i = 0; i < 40; i++) begin
		if ((ret ? return_valid_r : trap_branch_r) === 1'b1)
			break;
		go;
	end
	if (i == 40) begin
		errors++;
		give_verdict;
	end
endtask
task trap_seq(input [2:0] cs, input [13:0] tg, input op);
	await(0);
	chk(trap_cause_r, cs, "trap_cause");
	chk(trap_target_r, tg, "trap_target");
	chk(operand_trap_r, op, "operand_trap");
	await(1);
	chk(return_uaddr_r, cur_uaddr, "return_uaddr");
endtask
task fetch_beat(input den);
	stage_one_clock_edge = 1; instr_fetch = 1; go; stage_one_clock_edge = 0; instr_fetch = 0;
	chk(cache_addr_r, ep, "cache_addr");
	chk(tb_addr_r, ep, "tb_addr");
	chk(memory_address_reg_r, ep, "mem_addr");
	chk(instruction_backup_addr_r, ep, "instr_backup");
	access_denied = den; stage_two_clock_edge = 1; go; stage_two_clock_edge = 0;
	access_denied = 0; stage_two_half_clock_edge = 1; go; stage_two_half_clock_edge = 0;
	chk(instr_trap_pending_r, den, "trap_pending");
	ep = den ? ep : ep + 32'h0000_0002;
	chk(instruction_fetch_pointer_r, ep, "fetch_ptr");
endtask
task op_load(input [31:0] a);
	operand_addr = a; operand_fetch = 1; stage_six_clock_edge = 1; go;
	stage_six_clock_edge = 0; operand_fetch = 0;
	chk(operand_backup_addr_r, a, "operand_backup");
	chk(cache_addr_r, a, "operand_cache");
endtask
task op_trap(input [31:0] a, input ex, input den, input [1:0] md, input [2:0] cs, input [13:0] tg);
	op_load(a); go;
	chk(phys_page_r, tb_refill_page, "phys_page");
	cur_uaddr = 14'($urandom); exec_trap = ex; access_denied = den; cpu_mode = md;
	stage_seven_clock_edge = 1; go;
	stage_seven_clock_edge = 0; exec_trap = 0; access_denied = 0; cpu_mode = 2'h0;
	if (cs == 3'h0)
		chk(trap_branch_r, 0, "no_trap");
	else
		trap_seq(cs, tg, !ex);
endtask
function [31:0] stepped(input [15:0] v, input dn);
	// without flat addressing the low half wraps and the high half stays put
	return {16'h0000, dn ? v - 16'h0001 : v + 16'h0001};
endfunction
task str_op(input s, input [15:0] v, input dn);
	str_low_value = v; str_src_load = !s; str_dst_load = s; go; str_src_load = 0; str_dst_load = 0;
	chk(s ? string_dest_addr_r : string_source_addr_r, {16'h0000, v}, "str_load");
	str_down = dn; str_src_step = !s; str_dst_step = s; go; str_src_step = 0; str_dst_step = 0;
	chk(s ? string_dest_addr_r : string_source_addr_r, stepped(v, dn), "str_step");
	str_to_mem_addr_src = !s; str_to_mem_addr_dst = s; go;
	str_to_mem_addr_src = 0; str_to_mem_addr_dst = 0;
	chk(memory_address_reg_r, stepped(v, dn), "str_read");
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	{stage_one_clock_edge, stage_two_clock_edge, stage_two_half_clock_edge, stage_six_clock_edge,
		stage_seven_clock_edge, fetch_ptr_load, instr_fetch, operand_fetch, is32_access, instr_miss,
		operand_miss, unaligned_step, str_src_load, str_dst_load, str_src_step, str_dst_step,
		str_down, str_to_mem_addr_src, str_to_mem_addr_dst, access_denied, mapped_mode, exec_trap,
		tb_refill, slow} = '0;
	{fetch_ptr_value, operand_addr, str_low_value, keys, exec_trap_vector, cur_uaddr} = '0;
	{purge_count, cpu_mode} = '0;
	regfile_lo = 32'h0000_8010;
	regfile_hi = 32'h0000_801f;
	tb_refill_page = 16'h1234;
	srst = 1;
	void'($urandom(32'h2d50265f));
	repeat (6) go;
	srst = 0;
	ep = 32'h0000_8000;
	fetch_ptr_value = ep; fetch_ptr_load = 1; go; fetch_ptr_load = 0;
	chk(instruction_fetch_pointer_r, ep, "fetch_load");
	// first lookup misses; refill its entry before any trap is examined
	stage_one_clock_edge = 1; instr_fetch = 1; go; stage_one_clock_edge = 0; instr_fetch = 0;
	tb_refill = 1; go; tb_refill = 0;
	fetch_beat(0);
	slow = 1;
	cur_uaddr = 14'h0123;
	fetch_beat(1);
	trap_seq(3'h2, VEC, 0);
	chk(instruction_fetch_pointer_r, ep, "ptr_after_handler");
	slow = 0;
	exec_trap_vector = 14'($urandom);
	op_trap(32'h0000_8020, 1, 0, 2'h2, 3'h6, exec_trap_vector);
	op_trap(32'h0000_8020, 1, 1, 2'h2, 3'h6, exec_trap_vector);
	op_trap(32'h0000_8020, 0, 1, 2'h0, 3'h2, VEC);
	for (int m = 0; m < 4; m++)
		op_trap(32'h0000_8010, 0, 0, m[1:0], m == 3 ? 3'h0 : 3'h3, VEC);
	op_load(32'h0000_ffff);
	fetch_beat(0);
	operand_miss = 1; go; operand_miss = 0;
	chk(cache_addr_r, 32'h0000_ffff, "operand_restore");
	unaligned_step = 1; go; unaligned_step = 0;
	chk(cache_addr_r, 32'h0000_0000, "segment_wrap");
	instr_miss = 1; go; instr_miss = 0;
	chk(cache_addr_r, ep - 32'h0000_0002, "instr_restore");
	for (int k = 0; k < 24; k++) begin
		op_load($urandom);
		str_op(k[0], k == 0 ? 16'hffff : k == 1 ? 16'h0000 : 16'($urandom), k == 1 || $urandom % 2);
	end
	mapped_mode = 1; cpu_mode = 2'h3;
	for (int k = 0; k < 2; k++) begin
		keys = k[0] ? 16'h0004 : 16'h0000;
		str_low_value = 16'hffff; str_src_load = 1; go; str_src_load = 0;
		str_down = 0; str_src_step = 1; go; str_src_step = 0;
		chk(string_source_addr_r, k[0] ? 32'h0000_ffff : 32'h0000_0000, "wrap_step");
	end
	// flat trap: a 32-bit operand read at the last location of a segment
	is32_access = 1;
	op_load(32'h0000_ffff);
	tb_refill = 1; go; tb_refill = 0;
	op_trap(32'h0000_ffff, 0, 0, 2'h3, 3'h4, VEC);
	// wrap trap: a string step that would carry out of the low half
	is32_access = 0; cpu_mode = 2'h3;
	str_down = 0; str_src_step = 1; stage_seven_clock_edge = 1; go;
	str_src_step = 0; stage_seven_clock_edge = 0;
	trap_seq(3'h5, VEC, 1);
	chk(string_source_addr_r, 32'h0000_ffff, "wrap_hold");
	mapped_mode = 0; cpu_mode = 2'h0;
	chk(stack_overflow_r, 0, "stack_overflow");
	give_verdict;
end
endmodule // storage_address_and_trap_unit_test

// [core/satu_core.v]
// address generation and memory trap logic of the storage unit
// assumes stage edge inputs are one-cycle pulses from the pipeline clock divider
`timescale 1ns/1ps
`include "satu_regs.vh"
module satu_core #(
	parameter [`SATU_UADDR_W-1:0] TRAP_VECTOR = 14'h0040,
	parameter STACK_DEPTH = `SATU_STACK_DEPTH
) (
	input wire clk,
	input wire srst,
	input wire stage_one_clock_edge,
	input wire stage_two_clock_edge,
	input wire stage_two_half_clock_edge,
	input wire stage_six_clock_edge,
	input wire stage_seven_clock_edge,
	input wire fetch_ptr_load,
	input wire [`SATU_ADDR_W-1:0] fetch_ptr_value,
	input wire instr_fetch,
	input wire operand_fetch,
	input wire [`SATU_ADDR_W-1:0] operand_addr,
	input wire is32_access,
	input wire instr_miss,
	input wire operand_miss,
	input wire unaligned_step,
	input wire str_src_load,
	input wire str_dst_load,
	input wire [`SATU_HALF_W-1:0] str_low_value,
	input wire str_src_step,
	input wire str_dst_step,
	input wire str_down,
	input wire str_to_mem_addr_src,
	input wire str_to_mem_addr_dst,
	input wire access_denied,
	input wire [`SATU_MODE_W-1:0] cpu_mode,
	input wire mapped_mode,
	input wire [`SATU_HALF_W-1:0] keys,
	input wire [`SATU_ADDR_W-1:0] regfile_lo,
	input wire [`SATU_ADDR_W-1:0] regfile_hi,
	input wire exec_trap,
	input wire [`SATU_UADDR_W-1:0] exec_trap_vector,
	input wire [`SATU_UADDR_W-1:0] cur_uaddr,
	input wire trap_return,
	input wire pipe_drained,
	input wire tb_refill,
	input wire [`SATU_PAGE_W-1:0] tb_refill_page,
	input wire [`SATU_PURGE_W-1:0] purge_count,
	output reg [`SATU_ADDR_W-1:0] instruction_fetch_pointer_r,
	output reg [`SATU_ADDR_W-1:0] cache_addr_r,
	output reg [`SATU_ADDR_W-1:0] tb_addr_r,
	output reg [`SATU_ADDR_W-1:0] memory_address_reg_r,
	output reg [`SATU_ADDR_W-1:0] instruction_backup_addr_r,
	output reg [`SATU_ADDR_W-1:0] operand_backup_addr_r,
	output reg [`SATU_ADDR_W-1:0] string_source_addr_r,
	output reg [`SATU_ADDR_W-1:0] string_dest_addr_r,
	output reg [`SATU_PAGE_W-1:0] phys_page_r,
	output reg operand_trap_r,
	output reg instr_trap_pending_r,
	output reg trap_branch_r,
	output reg [`SATU_UADDR_W-1:0] trap_target_r,
	output reg [`SATU_CAUSE_W-1:0] trap_cause_r,
	output reg [`SATU_UADDR_W-1:0] return_uaddr_r,
	output reg return_valid_r,
	output reg stack_overflow_r
);
	////////////////////////////////////////////////////////////////////
	// translation buffer
	wire tb_hit;
	wire tb_miss;
	wire [`SATU_PAGE_W-1:0] tb_page;
	wire tb_lookup = stage_one_clock_edge | stage_six_clock_edge;
	wire [`SATU_ADDR_W-1:0] tb_lookup_addr =
		(stage_six_clock_edge && operand_fetch) ? operand_addr : instruction_fetch_pointer_r;
	satu_tlb u_tlb (
		.clk(clk),
		.srst(srst),
		.lookup_en(tb_lookup),
		.lookup_addr(tb_lookup_addr),
		.refill_en(tb_refill),
		.refill_page(tb_refill_page),
		.purge_count(purge_count),
		.hit_r(tb_hit),
		.miss_r(tb_miss),
		.page_r(tb_page)
	);

	////////////////////////////////////////////////////////////////////
	// trap cause decode
	wire in_regfile = tb_addr_r >= regfile_lo && tb_addr_r <= regfile_hi;
	wire regfile_mode = cpu_mode == `SATU_MODE_V || cpu_mode == `SATU_MODE_S ||
		cpu_mode == `SATU_MODE_R;
	wire flat_en = mapped_mode && cpu_mode == `SATU_MODE_I &&
		keys[`SATU_KEYS_FLAT_BIT];
	wire seg_last = tb_addr_r[`SATU_HALF_W-1:0] == `SATU_SEG_LAST_HALF;
	wire flat_hit = flat_en && is32_access && seg_last;
	wire src_carry = str_down ? (string_source_addr_r[15:0] == 16'h0000) :
		(string_source_addr_r[15:0] == 16'hffff);
	wire dst_carry = str_down ? (string_dest_addr_r[15:0] == 16'h0000) :
		(string_dest_addr_r[15:0] == 16'hffff);
	wire wrap_hit = flat_en && ((str_src_step && src_carry) ||
		(str_dst_step && dst_carry));
	reg [`SATU_CAUSE_W-1:0] mem_cause;
	always @* begin
		mem_cause = `SATU_CAUSE_NONE;
		if (tb_miss)
			mem_cause = `SATU_CAUSE_MISS;
		else if (access_denied)
			mem_cause = `SATU_CAUSE_ACCESS;
		else if (regfile_mode && in_regfile)
			mem_cause = `SATU_CAUSE_REGFILE;
		else if (flat_hit)
			mem_cause = `SATU_CAUSE_FLAT;
		else if (wrap_hit)
			mem_cause = `SATU_CAUSE_WRAP;
	end
	wire mem_trap = mem_cause != `SATU_CAUSE_NONE;
	wire instr_trap_now = stage_two_clock_edge && mem_trap;
	wire op_trap_now = stage_seven_clock_edge && mem_trap;

	////////////////////////////////////////////////////////////////////
	// trap state: blocks the increment and freezes address registers
	reg hold_inc_r;
	reg in_handler_r;
	reg [`SATU_CAUSE_W-1:0] instr_cause_r;
	// cause held from detection: the qualifying inputs are gone once the pipe drains
	always @(posedge clk) begin
		if (srst)
			instr_cause_r <= `SATU_CAUSE_NONE;
		else if (instr_trap_now)
			instr_cause_r <= mem_cause;
	end
	always @(posedge clk) begin
		if (srst) begin
			hold_inc_r <= 1'b0;
		end else if (instr_trap_now) begin
			hold_inc_r <= 1'b1;
		end else if (stage_two_half_clock_edge) begin
			hold_inc_r <= 1'b0;
		end
	end
	wire inc_ok = stage_two_half_clock_edge && !hold_inc_r && !instr_trap_now &&
		!in_handler_r;

	////////////////////////////////////////////////////////////////////
	// fetch pointer and cache/translation address registers
	wire [`SATU_ADDR_W-1:0] wrap_second = {operand_backup_addr_r[31:16], 16'h0000};
	wire op_seg_last = operand_backup_addr_r[`SATU_HALF_W-1:0] == `SATU_SEG_LAST_HALF;
	always @(posedge clk) begin
		if (srst) begin
			instruction_fetch_pointer_r <= `SATU_RESET_ADDR;
			cache_addr_r <= `SATU_RESET_ADDR;
			tb_addr_r <= `SATU_RESET_ADDR;
			memory_address_reg_r <= `SATU_RESET_ADDR;
			instruction_backup_addr_r <= `SATU_RESET_ADDR;
			operand_backup_addr_r <= `SATU_RESET_ADDR;
		end else begin
			if (fetch_ptr_load)
				instruction_fetch_pointer_r <= fetch_ptr_value;
			else if (inc_ok)
				instruction_fetch_pointer_r <=
					instruction_fetch_pointer_r + `SATU_FETCH_STEP;
			if (instr_miss) begin
				cache_addr_r <= instruction_backup_addr_r;
				tb_addr_r <= instruction_backup_addr_r;
			end else if (operand_miss) begin
				cache_addr_r <= operand_backup_addr_r;
				tb_addr_r <= operand_backup_addr_r;
			end else if (unaligned_step) begin
				// second half of a straddling access
				if (!flat_en && op_seg_last) begin
					cache_addr_r <= wrap_second;
				end else begin
					cache_addr_r <= operand_backup_addr_r + 32'h0000_0001;
				end
			end else if (in_handler_r) begin
				cache_addr_r <= cache_addr_r;
			end else if (stage_one_clock_edge && instr_fetch) begin
				cache_addr_r <= instruction_fetch_pointer_r;
				tb_addr_r <= instruction_fetch_pointer_r;
				memory_address_reg_r <= instruction_fetch_pointer_r;
				instruction_backup_addr_r <= instruction_fetch_pointer_r;
			end else if (stage_six_clock_edge && operand_fetch) begin
				cache_addr_r <= operand_addr;
				tb_addr_r <= operand_addr;
				operand_backup_addr_r <= operand_addr;
			end else if (str_to_mem_addr_src) begin
				memory_address_reg_r <= string_source_addr_r;
			end else if (str_to_mem_addr_dst) begin
				memory_address_reg_r <= string_dest_addr_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// string address registers: low half loads, high half loops back
	wire [`SATU_HALF_W-1:0] src_lo_step = str_down ?
		string_source_addr_r[15:0] - 16'h0001 : string_source_addr_r[15:0] + 16'h0001;
	wire [`SATU_HALF_W-1:0] dst_lo_step = str_down ?
		string_dest_addr_r[15:0] - 16'h0001 : string_dest_addr_r[15:0] + 16'h0001;
	always @(posedge clk) begin
		if (srst) begin
			string_source_addr_r <= `SATU_RESET_ADDR;
			string_dest_addr_r <= `SATU_RESET_ADDR;
		end else begin
			// high half carry is left to the wrap trap handler
			if (str_src_load)
				string_source_addr_r <= {string_source_addr_r[31:16], str_low_value};
			else if (str_src_step && !wrap_hit)
				string_source_addr_r <= {string_source_addr_r[31:16], src_lo_step};
			if (str_dst_load)
				string_dest_addr_r <= {string_dest_addr_r[31:16], str_low_value};
			else if (str_dst_step && !wrap_hit)
				string_dest_addr_r <= {string_dest_addr_r[31:16], dst_lo_step};
		end
	end

	////////////////////////////////////////////////////////////////////
	// trap dispatch and microcode return stack
	reg [`SATU_UADDR_W-1:0] stack_mem [0:STACK_DEPTH-1];
	reg [3:0] sp_r;
	wire go_instr = instr_trap_pending_r && pipe_drained && !in_handler_r;
	wire go_exec = stage_seven_clock_edge && exec_trap && !in_handler_r;
	wire go_op = op_trap_now && !exec_trap && !in_handler_r;
	wire take = go_exec || go_op || go_instr;
	always @(posedge clk) begin
		if (take && sp_r < STACK_DEPTH)
			stack_mem[sp_r[2:0]] <= cur_uaddr;
	end
	always @(posedge clk) begin
		if (srst) begin
			sp_r <= 4'h0;
			in_handler_r <= 1'b0;
			operand_trap_r <= 1'b0;
			instr_trap_pending_r <= 1'b0;
			trap_branch_r <= 1'b0;
			trap_target_r <= 14'h0000;
			trap_cause_r <= `SATU_CAUSE_NONE;
			return_uaddr_r <= 14'h0000;
			return_valid_r <= 1'b0;
			stack_overflow_r <= 1'b0;
			phys_page_r <= 16'h0000;
		end else begin
			trap_branch_r <= take;
			return_valid_r <= 1'b0;
			operand_trap_r <= go_op;
			if (tb_hit)
				phys_page_r <= tb_page;
			if (instr_trap_now)
				instr_trap_pending_r <= 1'b1;
			else if (go_instr)
				instr_trap_pending_r <= 1'b0;
			if (take) begin
				in_handler_r <= 1'b1;
				if (sp_r < STACK_DEPTH)
					sp_r <= sp_r + 4'h1;
				else
					stack_overflow_r <= 1'b1;
				if (go_exec) begin
					trap_target_r <= exec_trap_vector;
					trap_cause_r <= `SATU_CAUSE_EXEC;
				end else begin
					trap_target_r <= TRAP_VECTOR;
					trap_cause_r <= go_op ? mem_cause : instr_cause_r;
				end
			end else if (trap_return && in_handler_r && sp_r != 4'h0) begin
				in_handler_r <= 1'b0;
				sp_r <= sp_r - 4'h1;
				return_uaddr_r <= stack_mem[sp_r[2:0] - 3'h1];
				return_valid_r <= 1'b1;
			end
		end
	end
endmodule // satu_core

// [core/satu_regs.vh]
// constants for the storage address and trap unit
// assumes a single 40 MHz clock; stage edges arrive as one-cycle enable pulses
// Function
// - stage one end copies fetch pointer to address regs
// - fetch pointer advances two at next half edge
// - trap at stage two edge blocks that increment
// - instruction fetch loads memory, backup and cache regs
// - operand fetch at stage six loads backup and cache
// - operand backup restores miss and unaligned addresses
// - two 32-bit string address registers for microcode
// - translation buffer two sets of 512 entries
// - miss routine refills buffer then retries access
// - trap on miss, access violation, register-file address
// - trap pushes microaddress, jumps handler, later returns
// - operand trap detected in stage seven, pipeline told
// - handler end leaves address registers as trapped
// - execution traps outrank memory traps at stage seven
// - instruction traps found at stage two, pipeline drains
// - non-flat 32-bit access at segment end wraps
// - flat trap for reads crossing segment boundary
// - wrap trap for 32-bit string counter carry
// - flat and wrap need mapped, I mode, keys bit 2
// - each entry holds 3-bit purge count, 2 select bits
// - high half reloads itself when low half loads
`ifndef SATU_REGS_VH
`define SATU_REGS_VH
`define SATU_ADDR_W 32
`define SATU_HALF_W 16
`define SATU_TB_SETS 2
`define SATU_TB_ENTRIES_PER_SET 512
`define SATU_TB_IDX_W 9
`define SATU_PURGE_W 3
`define SATU_SEL_W 2
`define SATU_PAGE_W 16
`define SATU_TAG_W 14
`define SATU_UADDR_W 14
`define SATU_STACK_DEPTH 8
`define SATU_KEYS_FLAT_BIT 2
`define SATU_FETCH_STEP 32'h0000_0002
`define SATU_RESET_ADDR 32'h0000_0000
`define SATU_SEG_LAST_HALF 16'hffff
`define SATU_MODE_W 2
`define SATU_MODE_S 2'h0
`define SATU_MODE_R 2'h1
`define SATU_MODE_V 2'h2
`define SATU_MODE_I 2'h3
`define SATU_CAUSE_W 3
`define SATU_CAUSE_NONE 3'h0
`define SATU_CAUSE_MISS 3'h1
`define SATU_CAUSE_ACCESS 3'h2
`define SATU_CAUSE_REGFILE 3'h3
`define SATU_CAUSE_FLAT 3'h4
`define SATU_CAUSE_WRAP 3'h5
`define SATU_CAUSE_EXEC 3'h6
`endif

// [core/satu_tlb.v]
// two-set segment translation buffer with hit detection and refill
// assumes lookups and refills are stage-enable qualified by the caller
`timescale 1ns/1ps
`include "satu_regs.vh"
module satu_tlb #(
	parameter ENTRIES = `SATU_TB_ENTRIES_PER_SET,
	parameter IDX_W = `SATU_TB_IDX_W
) (
	input wire clk,
	input wire srst,
	input wire lookup_en,
	input wire [`SATU_ADDR_W-1:0] lookup_addr,
	input wire refill_en,
	input wire [`SATU_PAGE_W-1:0] refill_page,
	input wire [`SATU_PURGE_W-1:0] purge_count,
	output reg hit_r,
	output reg miss_r,
	output reg [`SATU_PAGE_W-1:0] page_r
);
	// entry layout: valid, sel bits, purge count, tag, page
	localparam ENT_W = 1 + `SATU_SEL_W + `SATU_PURGE_W + `SATU_TAG_W + `SATU_PAGE_W;
	reg [ENT_W-1:0] set0_mem [0:ENTRIES-1];
	reg [ENT_W-1:0] set1_mem [0:ENTRIES-1];
	reg victim_r;
	// valid bits are cleared by reset so an unwritten entry never reads as a hit
	reg [ENTRIES-1:0] val0_r;
	reg [ENTRIES-1:0] val1_r;
	reg [`SATU_ADDR_W-1:0] last_addr_r;
	wire [IDX_W-1:0] idx = lookup_addr[IDX_W+9:10];
	wire [`SATU_TAG_W-1:0] tag = lookup_addr[`SATU_ADDR_W-1:`SATU_ADDR_W-`SATU_TAG_W];
	wire [ENT_W-1:0] e0 = set0_mem[idx];
	wire [ENT_W-1:0] e1 = set1_mem[idx];
	localparam TAG_LO = `SATU_PAGE_W;
	localparam PRG_LO = TAG_LO + `SATU_TAG_W;
	// stale purge count counts as a miss so a purge needs no sweep
	wire hit0 = val0_r[idx] && e0[ENT_W-1] && e0[TAG_LO+`SATU_TAG_W-1:TAG_LO] == tag &&
		e0[PRG_LO+`SATU_PURGE_W-1:PRG_LO] == purge_count;
	wire hit1 = val1_r[idx] && e1[ENT_W-1] && e1[TAG_LO+`SATU_TAG_W-1:TAG_LO] == tag &&
		e1[PRG_LO+`SATU_PURGE_W-1:PRG_LO] == purge_count;
	wire [IDX_W-1:0] ridx = last_addr_r[IDX_W+9:10];
	wire [`SATU_TAG_W-1:0] rtag =
		last_addr_r[`SATU_ADDR_W-1:`SATU_ADDR_W-`SATU_TAG_W];
	wire [ENT_W-1:0] new_ent = {1'b1, {1'b0, victim_r}, purge_count, rtag, refill_page};
	always @(posedge clk) begin
		if (refill_en && !victim_r)
			set0_mem[ridx] <= new_ent;
		if (refill_en && victim_r)
			set1_mem[ridx] <= new_ent;
	end
	always @(posedge clk) begin
		if (srst) begin
			hit_r <= 1'b0;
			miss_r <= 1'b0;
			page_r <= 16'h0000;
			victim_r <= 1'b0;
			val0_r <= {ENTRIES{1'b0}};
			val1_r <= {ENTRIES{1'b0}};
			last_addr_r <= `SATU_RESET_ADDR;
		end else begin
			if (lookup_en) begin
				last_addr_r <= lookup_addr;
				hit_r <= hit0 | hit1;
				miss_r <= !(hit0 | hit1);
				page_r <= hit1 ? e1[`SATU_PAGE_W-1:0] : e0[`SATU_PAGE_W-1:0];
			end
			if (refill_en && !victim_r)
				val0_r[ridx] <= 1'b1;
			if (refill_en && victim_r)
				val1_r[ridx] <= 1'b1;
			if (refill_en)
				victim_r <= ~victim_r;
		end
	end
endmodule // satu_tlb
